/* hdl/cache_pkg.sv */
`default_nettype none
package cache_pkg;
	// Address geometry
	localparam int VPN_LSB = 16;
	localparam int VPN_W = 16;
	localparam int SET_W = 7;
	localparam int WAYS = 4;
	localparam int HI_W = 9;
	localparam int LINE_LSB = 4;
	localparam int LINE_W = 12;
	localparam int IDX_W = 13;
	localparam int WORD_LSB = 2;
	localparam int RA_W = 30;
	localparam int PID_W = 7;
	// Register byte offsets
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] FAULT_OFS = 8'h04;
	localparam logic [7:0] ENT_SEL_OFS = 8'h08;
	localparam logic [7:0] ENT_TAG_OFS = 8'h0C;
	localparam logic [7:0] ENT_DATA_OFS = 8'h10;
	localparam logic [7:0] CMD_ADDR_OFS = 8'h14;
	localparam logic [7:0] CMD_OFS = 8'h18;
	// Field positions
	localparam int ST_PID_LSB = 0;
	localparam int ST_KERNEL_BIT = 8;
	localparam int ST_MISS_BIT = 9;
	localparam int ST_BUSY_BIT = 16;
	localparam int FAULT_XLAT_BIT = 0;
	localparam int FAULT_WPROT_BIT = 1;
	localparam int SEL_WAY_LSB = 8;
	localparam int ETAG_PID_LSB = 16;
	localparam int ETAG_INV_BIT = 31;
	localparam int EDATA_WR_BIT = 16;
	localparam int CMD_FLUSH_BIT = 0;
	localparam int CMD_CLEAR_BIT = 1;
	localparam int CMD_INSTR_BIT = 2;
	localparam int CMD_PEND_BIT = 31;
	// Reset values
	localparam logic [6:0] PID_RST = 7'h00;
	localparam logic KERNEL_RST = 1'b1;
	localparam logic MISS_RST = 1'b1;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {OP_LOAD, OP_STORE, OP_FLUSH, OP_CLEAR} op_t;
	typedef enum {ST_IDLE, ST_WB, ST_RELOAD, ST_FILL, ST_RETRY} state_t;
endpackage
`default_nettype wire

/* hdl/cache_controller.sv */
`timescale 1ns/100ps
`default_nettype none
module cache_controller
	import cache_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Processor references
	input wire logic ref_valid,
	input wire logic [31:0] ref_vaddr,
	input wire logic ref_store,
	input wire logic ref_instr,
	output logic ref_stall,
	output logic xlat_fault,
	output logic wprot_fault,
	// External cache RAMs
	output logic [IDX_W-1:0] cache_index,
	output logic [1:0] cache_word,
	input wire logic [VPN_W-1:0] tag_rd_trans,
	input wire logic tag_rd_dirty,
	input wire logic tag_rd_invalid,
	output logic tag_we,
	output logic [VPN_W-1:0] tag_wr_trans,
	output logic tag_wr_dirty,
	output logic tag_wr_invalid,
	output logic data_we,
	// Memory controller, one line per request
	output logic mem_req,
	output logic mem_write,
	output logic [RA_W-1:0] mem_raddr,
	input wire logic mem_done
);
	// Shared entry store: one for both reference kinds
	logic [HI_W-1:0] ent_hi [2**SET_W][WAYS];
	logic [PID_W-1:0] ent_pid [2**SET_W][WAYS];
	logic [VPN_W-1:0] ent_page [2**SET_W][WAYS];
	logic ent_wr [2**SET_W][WAYS];
	logic ent_inv [2**SET_W][WAYS];
	logic [PID_W-1:0] pid_r;
	logic kernel_r, miss_r, fault_xlat_r, fault_wprot_r, cmd_pend_r;
	logic [SET_W-1:0] sel_set_r;
	logic [1:0] sel_way_r;
	logic [31:0] cmd_addr_r;
	op_t cmd_op_r;
	logic cmd_instr_r;
	state_t state_r;
	logic s2_valid_r, s2_ok_r, s2_wr_r, s2_instr_r;
	op_t s2_op_r;
	logic [LINE_W-1:0] s2_line_r;
	logic [1:0] s2_word_r;
	logic [VPN_W-1:0] s2_trans_r;
	logic mem_req_r, mem_write_r;
	logic [RA_W-1:0] mem_raddr_r;
	logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
	logic [31:0] awaddr_r, wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic awpriv_r;
	logic [1:0] bresp_r, rresp_r;

	// Register decode shared by read and write paths
	function automatic logic reg_known(input logic [31:0] a);
		return a[31:8] == 24'h00_0000 && a[1:0] == 2'h0 && a[7:0] <= CMD_OFS;
	endfunction
	function automatic logic reg_priv(input logic [31:0] a);
		return a[7:0] == ENT_TAG_OFS || a[7:0] == ENT_DATA_OFS;
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	// Stage 1 source: processor first, pending command only in an idle slot
	logic use_cmd, s1_take, s1_instr;
	logic [31:0] s1_addr;
	op_t s1_op;
	assign use_cmd = !ref_valid && cmd_pend_r;
	assign s1_addr = use_cmd ? cmd_addr_r : ref_vaddr;
	assign s1_instr = use_cmd ? cmd_instr_r : ref_instr;
	assign s1_op = use_cmd ? cmd_op_r : (ref_store ? OP_STORE : OP_LOAD);
	assign s1_take = !ref_stall && (ref_valid || cmd_pend_r);

	// Entry lookup runs in the same cycle as the tag RAM read
	logic [SET_W-1:0] lk_set;
	logic lk_ok, lk_wr;
	logic [VPN_W-1:0] lk_page;
	assign lk_set = s1_addr[VPN_LSB +: SET_W] ^ pid_r;
	always_comb begin
		lk_ok = 1'b0;
		lk_wr = 1'b0;
		lk_page = '0;
		for (int w = 0; w < WAYS; w++) begin
			if (!ent_inv[lk_set][w] && ent_pid[lk_set][w] == pid_r &&
					ent_hi[lk_set][w] == s1_addr[31 -: HI_W]) begin
				lk_ok = 1'b1;
				lk_wr = ent_wr[lk_set][w];
				lk_page = ent_page[lk_set][w];
			end
		end
		if (kernel_r) begin
			lk_ok = 1'b1;
			lk_wr = 1'b1;
			lk_page = s1_addr[VPN_LSB +: VPN_W];
		end
	end

	// RAM address: incoming reference when idle, held reference while busy
	always_comb begin
		if (state_r == ST_IDLE) begin
			cache_index = {s1_addr[LINE_LSB +: LINE_W], s1_instr};
			cache_word = s1_addr[WORD_LSB +: 2];
		end else begin
			cache_index = {s2_line_r, s2_instr_r};
			cache_word = s2_word_r;
		end
	end

	// Stage 2 decisions against the tag read one cycle later
	logic s2_live, act, line_hit, victim_dirty, need, is_ref;
	assign s2_live = s2_valid_r && state_r == ST_IDLE;
	assign is_ref = s2_op_r == OP_LOAD || s2_op_r == OP_STORE;
	assign xlat_fault = s2_live && !s2_ok_r;
	assign wprot_fault = s2_live && s2_ok_r && s2_op_r == OP_STORE && !s2_wr_r;
	assign act = s2_live && s2_ok_r && !wprot_fault;
	// Force-miss hides the tag entirely, so no victim is ever written back
	assign line_hit = !miss_r && !tag_rd_invalid && tag_rd_trans == s2_trans_r;
	assign victim_dirty = !miss_r && !tag_rd_invalid && tag_rd_dirty;
	assign need = act && (s2_op_r == OP_FLUSH ? line_hit && tag_rd_dirty : !line_hit);
	assign ref_stall = need || state_r != ST_IDLE;
	assign data_we = act && s2_op_r == OP_STORE && line_hit;
	assign tag_we = data_we || state_r == ST_FILL;
	assign tag_wr_trans = s2_trans_r;
	// Cleared lines stay dirty: memory never held their new contents
	assign tag_wr_dirty = state_r == ST_FILL ? s2_op_r == OP_CLEAR : 1'b1;
	assign tag_wr_invalid = 1'b0;

	// Pipeline register between lookup and compare
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s2_valid_r <= 1'b0;
		end else if (state_r == ST_FILL && !(is_ref && !miss_r)) begin
			s2_valid_r <= 1'b0;
		end else if (!ref_stall) begin
			s2_valid_r <= s1_take;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s2_op_r <= OP_LOAD;
			s2_ok_r <= 1'b0;
			s2_wr_r <= 1'b0;
			s2_instr_r <= 1'b0;
			s2_line_r <= '0;
			s2_word_r <= '0;
			s2_trans_r <= '0;
		end else if (!ref_stall && s1_take) begin
			s2_op_r <= s1_op;
			s2_ok_r <= lk_ok;
			s2_wr_r <= lk_wr;
			s2_instr_r <= s1_instr;
			s2_line_r <= s1_addr[LINE_LSB +: LINE_W];
			s2_word_r <= s1_addr[WORD_LSB +: 2];
			s2_trans_r <= lk_page;
		end
	end

	// Miss, flush and clear sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (need) begin
						if (victim_dirty) state_r <= ST_WB;
						else if (is_ref) state_r <= ST_RELOAD;
						else state_r <= ST_FILL;
					end
				end
				ST_WB: begin
					if (mem_done) state_r <= is_ref ? ST_RELOAD : ST_FILL;
				end
				ST_RELOAD: begin
					if (mem_done) state_r <= ST_FILL;
				end
				ST_FILL: state_r <= (is_ref && !miss_r) ? ST_RETRY : ST_IDLE;
				ST_RETRY: state_r <= ST_IDLE;
			endcase
		end
	end

	// Line transfer requests; real addresses are word addresses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_req_r <= 1'b0;
			mem_write_r <= 1'b0;
			mem_raddr_r <= '0;
		end else if (state_r == ST_IDLE && need && victim_dirty) begin
			mem_req_r <= 1'b1;
			mem_write_r <= 1'b1;
			mem_raddr_r <= {tag_rd_trans, s2_line_r, 2'b00};
		end else if ((state_r == ST_IDLE && need && is_ref) ||
				(state_r == ST_WB && mem_done && is_ref)) begin
			mem_req_r <= 1'b1;
			mem_write_r <= 1'b0;
			mem_raddr_r <= {s2_trans_r, s2_line_r, 2'b00};
		end else if (mem_done) begin
			mem_req_r <= 1'b0;
			mem_write_r <= 1'b0;
		end
	end
	assign mem_req = mem_req_r;
	assign mem_write = mem_write_r;
	assign mem_raddr = mem_raddr_r;

	// Write channel capture, either order
	logic wr_go, wr_err;
	assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_err = !reg_known(awaddr_r) || (reg_priv(awaddr_r) && !awpriv_r);
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready = !w_hold_r && !bvalid_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			awaddr_r <= '0;
			awpriv_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
				awpriv_r <= s_axi_awprot[0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_err ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// Register words as software sees them
	logic [31:0] status_w, fault_w, sel_w, etag_w, edata_w, cmd_w;
	always_comb begin
		status_w = '0;
		status_w[ST_PID_LSB +: PID_W] = pid_r;
		status_w[ST_KERNEL_BIT] = kernel_r;
		status_w[ST_MISS_BIT] = miss_r;
		status_w[ST_BUSY_BIT] = state_r != ST_IDLE;
		fault_w = '0;
		fault_w[FAULT_XLAT_BIT] = fault_xlat_r;
		fault_w[FAULT_WPROT_BIT] = fault_wprot_r;
		sel_w = '0;
		sel_w[0 +: SET_W] = sel_set_r;
		sel_w[SEL_WAY_LSB +: 2] = sel_way_r;
		etag_w = '0;
		etag_w[0 +: HI_W] = ent_hi[sel_set_r][sel_way_r];
		etag_w[ETAG_PID_LSB +: PID_W] = ent_pid[sel_set_r][sel_way_r];
		etag_w[ETAG_INV_BIT] = ent_inv[sel_set_r][sel_way_r];
		edata_w = '0;
		edata_w[0 +: VPN_W] = ent_page[sel_set_r][sel_way_r];
		edata_w[EDATA_WR_BIT] = ent_wr[sel_set_r][sel_way_r];
		cmd_w = '0;
		cmd_w[CMD_FLUSH_BIT] = cmd_op_r == OP_FLUSH;
		cmd_w[CMD_CLEAR_BIT] = cmd_op_r == OP_CLEAR;
		cmd_w[CMD_INSTR_BIT] = cmd_instr_r;
		cmd_w[CMD_PEND_BIT] = cmd_pend_r;
	end

	// Software-written control
	logic [31:0] wm;
	assign wm = wdata_r;
	// Write data laid over each register's present word, so narrow strobes keep the rest
	logic [31:0] st_m, sel_m, etag_m, edata_m;
	assign st_m = merge(status_w, wm, wstrb_r);
	assign sel_m = merge(sel_w, wm, wstrb_r);
	assign etag_m = merge(etag_w, wm, wstrb_r);
	assign edata_m = merge(edata_w, wm, wstrb_r);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pid_r <= PID_RST;
			kernel_r <= KERNEL_RST;
			miss_r <= MISS_RST;
			sel_set_r <= '0;
			sel_way_r <= '0;
			cmd_addr_r <= '0;
		end else if (wr_go && !wr_err) begin
			if (awaddr_r[7:0] == STATUS_OFS) begin
				pid_r <= st_m[ST_PID_LSB +: PID_W];
				kernel_r <= st_m[ST_KERNEL_BIT];
				miss_r <= st_m[ST_MISS_BIT];
			end
			if (awaddr_r[7:0] == ENT_SEL_OFS) begin
				sel_set_r <= sel_m[0 +: SET_W];
				sel_way_r <= sel_m[SEL_WAY_LSB +: 2];
			end
			if (awaddr_r[7:0] == CMD_ADDR_OFS) cmd_addr_r <= merge(cmd_addr_r, wm, wstrb_r);
		end
	end

	// Line commands: pending until stage 1 takes them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_pend_r <= 1'b0;
			cmd_op_r <= OP_FLUSH;
			cmd_instr_r <= 1'b0;
		end else if (wr_go && !wr_err && awaddr_r[7:0] == CMD_OFS && wstrb_r[0] &&
				(wm[CMD_FLUSH_BIT] || wm[CMD_CLEAR_BIT])) begin
			cmd_pend_r <= 1'b1;
			cmd_op_r <= wm[CMD_CLEAR_BIT] ? OP_CLEAR : OP_FLUSH;
			cmd_instr_r <= wm[CMD_INSTR_BIT];
		end else if (s1_take && use_cmd) begin
			cmd_pend_r <= 1'b0;
		end
	end

	// Sticky fault flags; a new fault beats a same-cycle clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_xlat_r <= 1'b0;
			fault_wprot_r <= 1'b0;
		end else begin
			if (xlat_fault) fault_xlat_r <= 1'b1;
			else if (wr_go && !wr_err && awaddr_r[7:0] == FAULT_OFS && wstrb_r[0] &&
					wm[FAULT_XLAT_BIT]) fault_xlat_r <= 1'b0;
			if (wprot_fault) fault_wprot_r <= 1'b1;
			else if (wr_go && !wr_err && awaddr_r[7:0] == FAULT_OFS && wstrb_r[0] &&
					wm[FAULT_WPROT_BIT]) fault_wprot_r <= 1'b0;
		end
	end

	// Entry contents, privileged writes only; invalid bits start set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int s = 0; s < 2**SET_W; s++) begin
				for (int w = 0; w < WAYS; w++) ent_inv[s][w] <= 1'b1;
			end
		end else if (wr_go && !wr_err && awaddr_r[7:0] == ENT_TAG_OFS) begin
			ent_inv[sel_set_r][sel_way_r] <= etag_m[ETAG_INV_BIT];
		end
	end
	always_ff @(posedge aclk) begin
		if (wr_go && !wr_err && awaddr_r[7:0] == ENT_TAG_OFS) begin
			ent_hi[sel_set_r][sel_way_r] <= etag_m[0 +: HI_W];
			ent_pid[sel_set_r][sel_way_r] <= etag_m[ETAG_PID_LSB +: PID_W];
		end
		if (wr_go && !wr_err && awaddr_r[7:0] == ENT_DATA_OFS) begin
			ent_page[sel_set_r][sel_way_r] <= edata_m[0 +: VPN_W];
			ent_wr[sel_set_r][sel_way_r] <= edata_m[EDATA_WR_BIT];
		end
	end

	// Read channel: one cycle to data
	logic [31:0] rd_mux;
	always_comb begin
		unique case (s_axi_araddr[7:0])
			STATUS_OFS: rd_mux = status_w;
			FAULT_OFS: rd_mux = fault_w;
			ENT_SEL_OFS: rd_mux = sel_w;
			ENT_TAG_OFS: rd_mux = etag_w;
			ENT_DATA_OFS: rd_mux = edata_w;
			CMD_ADDR_OFS: rd_mux = cmd_addr_r;
			CMD_OFS: rd_mux = cmd_w;
			default: rd_mux = '0;
		endcase
	end
	assign s_axi_arready = !rvalid_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_r) begin
			rvalid_r <= 1'b1;
			if (!reg_known(s_axi_araddr) || (reg_priv(s_axi_araddr) && !s_axi_arprot[0])) begin
				rdata_r <= '0;
				rresp_r <= RESP_SLVERR;
			end else begin
				rdata_r <= rd_mux;
				rresp_r <= RESP_OKAY;
			end
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// Checks on the lookup and miss sequencing
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence dirty_miss_s;
		act && is_ref && !line_hit && victim_dirty;
	endsequence
	sequence store_take_s;
		s1_take && s1_op == OP_STORE && lk_ok && !lk_wr;
	endsequence
	wb_first_a: assert property (dirty_miss_s |=> mem_req && mem_write && state_r == ST_WB)
		else $error("dirty victim not written back first");
	victim_addr_a: assert property (dirty_miss_s |=>
		mem_raddr == {$past(tag_rd_trans), $past(s2_line_r), 2'b00})
		else $error("victim address wrong");
	reload_addr_a: assert property ((state_r == ST_RELOAD && mem_req) |->
		mem_raddr == {s2_trans_r, s2_line_r, 2'b00} && !mem_write)
		else $error("reload address wrong");
	miss_we_a: assert property ((s2_live && s2_op_r == OP_STORE &&
		(miss_r || tag_rd_invalid || tag_rd_trans != s2_trans_r)) |-> !data_we)
		else $error("store miss wrote RAM");
	force_miss_a: assert property ((miss_r && act && s2_op_r != OP_FLUSH) |=>
		state_r != ST_IDLE && !mem_write)
		else $error("force miss did not miss cleanly");
	kernel_ok_a: assert property ((kernel_r && s1_take) |=> !xlat_fault)
		else $error("fault in kernel mode");
	wprot_hit_a: assert property (store_take_s |=> wprot_fault && !data_we && !tag_we)
		else $error("write protect not signalled");
	fault_sticky_a: assert property (xlat_fault |=> fault_xlat_r[*2])
		else $error("fault flag not held");
endmodule // cache_controller
`default_nettype wire

/* bench/far_side.sv */
`timescale 1ns/100ps
`default_nettype none
module far_side
	import cache_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Tag RAM
	input wire logic [IDX_W-1:0] cache_index,
	input wire logic tag_we,
	input wire logic [VPN_W-1:0] tag_wr_trans,
	input wire logic tag_wr_dirty,
	input wire logic tag_wr_invalid,
	output logic [VPN_W-1:0] tag_rd_trans,
	output logic tag_rd_dirty,
	output logic tag_rd_invalid,
	// Memory controller
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic [RA_W-1:0] mem_raddr,
	input wire logic [3:0] mem_delay,
	output logic mem_done
);
	logic [VPN_W-1:0] trans_m [2**IDX_W];
	logic dirty_m [2**IDX_W];
	logic inv_m [2**IDX_W];
	logic [30:0] log_q [$];
	logic busy_r = 1'b0;
	logic [3:0] cnt_r = 4'h0;
	// Power-up junk: dirty lines with made-up tags, so boot has to force misses
	initial begin
		for (int i = 0; i < 2**IDX_W; i++) begin
			trans_m[i] = 16'(i) ^ 16'h5A5A;
			dirty_m[i] = 1'b1;
			inv_m[i] = 1'b0;
		end
		tag_rd_trans = 16'h0000;
		tag_rd_dirty = 1'b0;
		tag_rd_invalid = 1'b1;
		mem_done = 1'b0;
	end
	// Synchronous tag RAM, read data one cycle after the index
	always @(posedge aclk) begin
		tag_rd_trans <= trans_m[cache_index];
		tag_rd_dirty <= dirty_m[cache_index];
		tag_rd_invalid <= inv_m[cache_index];
		if (tag_we) begin
			trans_m[cache_index] <= tag_wr_trans;
			dirty_m[cache_index] <= tag_wr_dirty;
			inv_m[cache_index] <= tag_wr_invalid;
		end
	end
	// Whole-line transfers; the bench sets how long each one takes
	always @(posedge aclk) begin
		mem_done <= 1'b0;
		if (busy_r) begin
			if (cnt_r == 4'h0) begin
				mem_done <= 1'b1;
				busy_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r - 4'h1;
			end
		end else if (mem_req && !mem_done) begin
			busy_r <= 1'b1;
			cnt_r <= mem_delay;
			log_q.push_back({mem_write, mem_raddr});
		end
	end
endmodule // far_side
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin \
	samples_checked++; \
	if ((got) !== (ex)) begin \
		fails++; \
		$display("BAD %s expected %h seen %h", nm, ex, got); \
	end \
end
module testbench
	import cache_pkg::*;
;
	localparam logic [31:0] VA_A = 32'h0012_3450;
	localparam logic [31:0] VA_B = 32'h0034_3458;
	localparam logic [31:0] VA_C = 32'h0012_0008;
	localparam logic [31:0] VA_D = 32'h0056_7890;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic [3:0] s_axi_wstrb = 4'hF, mem_delay = 4'h1, seen;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, cache_word, rsp;
	// Only the bench drives the virtual address
	logic ref_valid = 1'b0, ref_store = 1'b0, ref_instr = 1'b0;
	logic [31:0] ref_vaddr = '0;
	logic ref_stall, xlat_fault, wprot_fault, tag_we, tag_wr_dirty, tag_wr_invalid, data_we;
	logic mem_req, mem_write, mem_done, tag_rd_dirty, tag_rd_invalid;
	logic [IDX_W-1:0] cache_index;
	logic [VPN_W-1:0] tag_rd_trans, tag_wr_trans;
	logic [RA_W-1:0] mem_raddr;
	int fails = 0;
	int samples_checked = 0;
	always #50 aclk = ~aclk;
	cache_controller i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_valid,
		.ref_vaddr, .ref_store, .ref_instr, .ref_stall, .xlat_fault, .wprot_fault, .cache_index,
		.cache_word, .tag_rd_trans, .tag_rd_dirty, .tag_rd_invalid, .tag_we, .tag_wr_trans,
		.tag_wr_dirty, .tag_wr_invalid, .data_we, .mem_req, .mem_write, .mem_raddr, .mem_done);
	far_side i_far (.aclk, .cache_index, .tag_we, .tag_wr_trans, .tag_wr_dirty,
		.tag_wr_invalid, .tag_rd_trans, .tag_rd_dirty, .tag_rd_invalid, .mem_req, .mem_write,
		.mem_raddr, .mem_delay, .mem_done);
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Both write channels offered together, each dropped at the edge that takes it
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p,
		input logic [1:0] er);
		logic ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		s_axi_awaddr <= {24'h00_0000, a};
		s_axi_wdata <= d;
		s_axi_awprot <= p;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ad && dd)) begin
			@(posedge aclk);
			if (!ad && s_axi_awready) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!dd && s_axi_wready) begin
				dd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CHK("bresp", er, s_axi_bresp)
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [2:0] p);
		s_axi_araddr <= {24'h00_0000, a};
		s_axi_arprot <= p;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [2:0] p, input logic [31:0] ed,
		input logic [1:0] er);
		axi_rd(a, p);
		`CHK("read", {er, ed}, {rsp, rd})
	endtask
	// Stage-two outputs sampled in the cycle after the take; ex is {stall, xlat, wprot, we}
	task automatic ref_op(input logic [31:0] va, input logic st, input logic ins,
		input logic [3:0] ex);
		int n;
		ref_vaddr <= va;
		ref_store <= st;
		ref_instr <= ins;
		ref_valid <= 1'b1;
		do @(posedge aclk); while (ref_stall);
		`CHK("cache_index", {va[15:4], ins}, cache_index)
		`CHK("cache_word", va[3:2], cache_word)
		ref_valid <= 1'b0;
		@(posedge aclk);
		seen = {ref_stall, xlat_fault, wprot_fault, data_we};
		n = 0;
		while (ref_stall && n < 400) begin
			@(posedge aclk);
			n++;
		end
		`CHK("stall_end", 1'b0, ref_stall)
		`CHK("ref_result", ex, seen)
		@(posedge aclk);
	endtask
	task automatic chk_mem(input logic w, input logic [RA_W-1:0] a);
		logic [30:0] e;
		e = 'x;
		if (i_far.log_q.size() > 0)
			e = i_far.log_q.pop_front();
		`CHK("mem_xfer", {w, a}, e)
	endtask
	// Command, then poll pending so no reference overlaps it
	task automatic run_cmd(input logic [31:0] va, input logic [31:0] c);
		int n;
		axi_wr(CMD_ADDR_OFS, va, 3'h1, RESP_OKAY);
		axi_wr(CMD_OFS, c, 3'h1, RESP_OKAY);
		n = 0;
		rd = 32'h8000_0000;
		while (rd[CMD_PEND_BIT] && n < 50) begin
			axi_rd(CMD_OFS, 3'h1);
			n++;
		end
		`CHK("cmd_taken", 1'b0, rd[CMD_PEND_BIT])
		// Pending drops at injection; the line transfer itself only shows as busy
		rd = 32'h0001_0000;
		while (rd[ST_BUSY_BIT] && n < 100) begin
			axi_rd(STATUS_OFS, 3'h1);
			n++;
		end
		`CHK("cmd_done", 1'b0, rd[ST_BUSY_BIT])
	endtask
	initial begin
		#2000000;
		fails++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(STATUS_OFS, 3'h0, 32'h0000_0300, RESP_OKAY);
		rd_chk(8'h1C, 3'h0, 32'h0000_0000, RESP_SLVERR);
		axi_wr(8'h20, 32'h0000_0000, 3'h0, RESP_SLVERR);
		// Boot: forced misses reload over junk dirty lines without writing them back
		ref_op(VA_A, 1'b0, 1'b0, 4'b1000);
		chk_mem(1'b0, {VA_A[31:4], 2'b00});
		ref_op(VA_A, 1'b0, 1'b1, 4'b1000);
		chk_mem(1'b0, {VA_A[31:4], 2'b00});
		axi_wr(STATUS_OFS, 32'h0000_0100, 3'h0, RESP_OKAY);
		ref_op(VA_A, 1'b0, 1'b0, 4'b0000);
		ref_op(VA_A, 1'b0, 1'b1, 4'b0000);
		ref_op(VA_A, 1'b1, 1'b0, 4'b0001);
		mem_delay <= 4'h6;
		ref_op(VA_B, 1'b0, 1'b0, 4'b1000);
		chk_mem(1'b1, {VA_A[31:4], 2'b00});
		chk_mem(1'b0, {VA_B[31:4], 2'b00});
		ref_op(VA_A, 1'b0, 1'b1, 4'b0000);
		ref_op(VA_C, 1'b1, 1'b0, 4'b1000);
		i_far.log_q.delete();
		ref_op(VA_B, 1'b1, 1'b0, 4'b0001);
		run_cmd(VA_B, 32'h0000_0001);
		chk_mem(1'b1, {VA_B[31:4], 2'b00});
		`CHK("log_size", 0, i_far.log_q.size())
		ref_op(VA_B, 1'b0, 1'b0, 4'b0000);
		run_cmd(VA_D, 32'h0000_0002);
		chk_mem(1'b1, {16'h5548, VA_D[15:4], 2'b00});
		`CHK("log_size", 0, i_far.log_q.size())
		ref_op(VA_D, 1'b0, 1'b0, 4'b0000);
		// User mode, pid 5, no entries yet
		axi_wr(STATUS_OFS, 32'h0000_0005, 3'h0, RESP_OKAY);
		ref_op(VA_A, 1'b0, 1'b0, 4'b0100);
		rd_chk(FAULT_OFS, 3'h0, 32'h0000_0001, RESP_OKAY);
		axi_wr(FAULT_OFS, 32'h0000_0001, 3'h0, RESP_OKAY);
		rd_chk(FAULT_OFS, 3'h0, 32'h0000_0000, RESP_OKAY);
		axi_wr(ENT_TAG_OFS, 32'h0005_0000, 3'h0, RESP_SLVERR);
		rd_chk(ENT_TAG_OFS, 3'h0, 32'h0000_0000, RESP_SLVERR);
		// One entry only for this page, in set 0x12 ^ 5, way 2
		axi_wr(ENT_SEL_OFS, 32'h0000_0217, 3'h1, RESP_OKAY);
		axi_wr(ENT_TAG_OFS, 32'h0005_0000, 3'h1, RESP_OKAY);
		axi_wr(ENT_DATA_OFS, 32'h0000_0ABC, 3'h1, RESP_OKAY);
		ref_op(VA_A, 1'b0, 1'b0, 4'b1000);
		chk_mem(1'b0, {16'h0ABC, VA_A[15:4], 2'b00});
		ref_op(VA_A, 1'b1, 1'b0, 4'b0010);
		axi_wr(STATUS_OFS, 32'h0000_0006, 3'h0, RESP_OKAY);
		ref_op(VA_A, 1'b0, 1'b0, 4'b0100);
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
